/* File: hdl/sfqc_pkg.sv */
package sfqc_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE = 8'hc7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RDP = 8'hab;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_WRAP_RD = 8'h0c;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_WQIO = 8'he7;
  localparam logic [7:0] OP_OQIO = 8'he3;
  localparam logic [7:0] OP_SETWRAP = 8'h77;
  localparam logic [7:0] OP_SETPARAM = 8'hc0;
  localparam logic [7:0] OP_SECPRG = 8'h42;
  localparam logic [7:0] OP_SECERS = 8'h44;
  localparam logic [7:0] OP_SECRD = 8'h48;
  localparam logic [7:0] OP_QPI_EN = 8'h38;
  localparam logic [7:0] OP_QPI_DIS = 8'hff;
  localparam logic [7:0] OP_RESET = 8'h99;
  // ==========================================================
  // Address fields and counts
  localparam logic [7:0] SEC_HI = 8'h00;
  localparam logic [7:0] SEC_R1 = 8'h10;
  localparam logic [7:0] SEC_R2 = 8'h20;
  localparam logic [7:0] SEC_R3 = 8'h30;
  localparam logic [15:0] PAGE_BYTES = 16'h0100;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
  localparam logic [4:0] QIO_DUMMY = 5'h04;
  localparam logic [4:0] WQIO_DUMMY = 5'h02;
  localparam logic [4:0] RDP_DUMMY_1 = 5'h18;
  localparam logic [4:0] RDP_DUMMY_4 = 5'h06;
  localparam logic [3:0] DUMMY_FLD_RST = 4'h2;
  localparam logic [3:0] WRAP_FLD_RST = 4'h0;
  // ==========================================================
  // Pin levels and timing
  localparam logic [3:0] OE_IDLE = 4'hc;
  localparam logic [3:0] OE_SINGLE = 4'hd;
  localparam logic [3:0] OE_ALL = 4'hf;
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [1:0] IO_HI = 2'h3;
  localparam int CLK_NS = 10;
  localparam int SCLK_NS = 80;
  localparam int SCLK_HALF_CYC = SCLK_NS / (2 * CLK_NS);
  localparam int CS_GAP_NS = 50;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {lane_1 = 2'h0, lane_2 = 2'h1, lane_4 = 2'h2} sfqc_lane_t;
  typedef enum logic [2:0] {ph_op, ph_addr, ph_dummy, ph_wr, ph_rd} sfqc_ph_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] mode_bits;
    logic has_addr;
    logic has_mode;
    sfqc_lane_t addr_lanes;
    sfqc_lane_t data_lanes;
    logic [4:0] dummy_clks;
    logic rd_dir;
    logic [15:0] data_len;
  } sfqc_cmd_t;

  function automatic logic [5:0] nclk(input logic [5:0] bits, input sfqc_lane_t l);
    nclk = bits >> l;
  endfunction : nclk
endpackage : sfqc_pkg

/* File: hdl/sfqc_host.sv */
`timescale 1ns/10ps
module sfqc_host #(
  parameter int HALF_CYC = sfqc_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = sfqc_pkg::CS_GAP_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input sfqc_pkg::sfqc_cmd_t cmd_i,
  output logic cmd_err_o,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic four_wire_command_mode_o,
  output logic write_enable_latch_o,
  output logic [3:0] dummy_count_field_o,
  output logic [3:0] wrap_length_field_o,
  output logic flash_sclk_o,
  output logic flash_cs_b_o,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {st_idle, st_run, st_gap} sfqc_st_t;
  localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
  localparam logic [7:0] GAP_END = 8'(GAP_CYC - 1);
  sfqc_st_t st_r;
  sfqc_pkg::sfqc_ph_t ph_r;
  sfqc_pkg::sfqc_ph_t nxt_ph;
  sfqc_pkg::sfqc_ph_t data_ph;
  sfqc_pkg::sfqc_lane_t lane_r;
  sfqc_pkg::sfqc_lane_t addr_lane_r;
  sfqc_pkg::sfqc_lane_t data_lane_r;
  sfqc_pkg::sfqc_lane_t e_addr_lane;
  sfqc_pkg::sfqc_lane_t e_data_lane;
  sfqc_pkg::sfqc_lane_t e_op_lane;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic nxt_end;
  logic sclk_r;
  logic [7:0] div_r;
  logic [7:0] gap_r;
  logic [31:0] sh_r;
  logic [31:0] addr_word_r;
  logic [31:0] e_word;
  logic [5:0] cnt_r;
  logic [5:0] addr_clks_r;
  logic [4:0] dummy_r;
  logic [4:0] e_dummy;
  logic [15:0] len_r;
  logic [15:0] e_len;
  logic has_addr_r;
  logic e_has_addr;
  logic e_has_mode;
  logic dir_r;
  logic [7:0] op_r;
  logic [7:0] rx_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic err_r;
  logic qpi_r;
  logic wel_r;
  logic [3:0] dummy_fld_r;
  logic [3:0] wrap_fld_r;
  logic [3:0] io_o_r;
  logic [3:0] io_oe_r;
  logic take;
  logic is_wr;
  logic is_prog;
  logic is_sec;
  logic bad;
  logic rise;
  logic fall_t;
  logic fall;
  logic last;
  logic need_wr;
  logic frame_end;
  logic [7:0] op;

  assign op = cmd_i.opcode;
  assign take = cmd_valid_i && (st_r == st_idle);
  assign cmd_ready_o = (st_r == st_idle);
  assign cmd_err_o = err_r;
  assign busy_o = (st_r != st_idle);
  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign four_wire_command_mode_o = qpi_r;
  assign write_enable_latch_o = wel_r;
  assign dummy_count_field_o = dummy_fld_r;
  assign wrap_length_field_o = wrap_fld_r;
  assign flash_sclk_o = sclk_r;
  assign flash_cs_b_o = (st_r != st_run);
  assign io_o = io_o_r;
  assign io_oe_o = io_oe_r;

  // ==========================================================
  // Pin input synchroniser
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end
    else
    begin
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
    end
  end

  // ==========================================================
  // Command screening
  // Commands the flash would reject or misread are refused here, so the
  // shadow state below never drifts from the device.
  always_comb
  begin
    is_wr = op inside {sfqc_pkg::OP_PP, sfqc_pkg::OP_QPP, sfqc_pkg::OP_SE,
                       sfqc_pkg::OP_BE32, sfqc_pkg::OP_BE64, sfqc_pkg::OP_CE,
                       sfqc_pkg::OP_CE2, sfqc_pkg::OP_WRSR, sfqc_pkg::OP_SECPRG,
                       sfqc_pkg::OP_SECERS};
    is_prog = op inside {sfqc_pkg::OP_PP, sfqc_pkg::OP_QPP, sfqc_pkg::OP_SECPRG};
    is_sec = op inside {sfqc_pkg::OP_SECPRG, sfqc_pkg::OP_SECERS, sfqc_pkg::OP_SECRD};
    bad = 1'b0;
    if (is_wr && !wel_r)
      bad = 1'b1;
    if (is_prog && (cmd_i.data_len == 16'h0 || cmd_i.data_len > sfqc_pkg::PAGE_BYTES))
      bad = 1'b1;
    if (is_sec && (cmd_i.addr[23:16] != sfqc_pkg::SEC_HI ||
        !(cmd_i.addr[15:8] inside {sfqc_pkg::SEC_R1, sfqc_pkg::SEC_R2, sfqc_pkg::SEC_R3})))
      bad = 1'b1;
    if (op == sfqc_pkg::OP_WQIO && cmd_i.addr[0])
      bad = 1'b1;
    if (op == sfqc_pkg::OP_OQIO && cmd_i.addr[3:0] != 4'h0)
      bad = 1'b1;
    if (op == sfqc_pkg::OP_WRAP_RD && !qpi_r)
      bad = 1'b1;
  end

  // ==========================================================
  // Effective frame layout
  always_comb
  begin
    e_op_lane = qpi_r ? sfqc_pkg::lane_4 : sfqc_pkg::lane_1;
    e_data_lane = qpi_r ? sfqc_pkg::lane_4 : cmd_i.data_lanes;
    e_addr_lane = cmd_i.addr_lanes;
    if (qpi_r || op inside {sfqc_pkg::OP_QIO, sfqc_pkg::OP_WQIO, sfqc_pkg::OP_OQIO,
                            sfqc_pkg::OP_SETWRAP})
      e_addr_lane = sfqc_pkg::lane_4;
    e_has_addr = cmd_i.has_addr;
    e_len = cmd_i.data_len;
    if (op inside {sfqc_pkg::OP_SUSP, sfqc_pkg::OP_RESUME, sfqc_pkg::OP_WREN,
                   sfqc_pkg::OP_WRDI})
    begin
      e_has_addr = 1'b0;
      e_len = 16'h0;
    end
    e_has_mode = cmd_i.has_mode;
    e_word = {cmd_i.addr, cmd_i.has_mode ? cmd_i.mode_bits : 8'h00};
    if (op == sfqc_pkg::OP_SETWRAP)
    begin
      e_has_addr = 1'b1;
      e_has_mode = 1'b1;
      e_word = {24'h0, 1'b0, cmd_i.mode_bits[6:4], 4'h0};
    end
    e_dummy = cmd_i.dummy_clks;
    if (op == sfqc_pkg::OP_RDP)
      e_dummy = qpi_r ? sfqc_pkg::RDP_DUMMY_4 : sfqc_pkg::RDP_DUMMY_1;
    else if (qpi_r && op inside {sfqc_pkg::OP_FAST, sfqc_pkg::OP_WRAP_RD, sfqc_pkg::OP_QIO})
      e_dummy = {1'b0, dummy_fld_r};
    else if (op == sfqc_pkg::OP_QIO)
      e_dummy = sfqc_pkg::QIO_DUMMY;
    else if (op == sfqc_pkg::OP_WQIO)
      e_dummy = sfqc_pkg::WQIO_DUMMY;
    else if (op == sfqc_pkg::OP_OQIO)
      e_dummy = 5'h0;
  end

  // ==========================================================
  // Phase sequencing
  assign data_ph = dir_r ? sfqc_pkg::ph_rd : sfqc_pkg::ph_wr;
  always_comb
  begin
    nxt_ph = data_ph;
    nxt_end = (len_r == 16'h0);
    case (ph_r)
      sfqc_pkg::ph_op:
      begin
        if (has_addr_r)
        begin
          nxt_ph = sfqc_pkg::ph_addr;
          nxt_end = 1'b0;
        end
        else if (dummy_r != 5'h0)
        begin
          nxt_ph = sfqc_pkg::ph_dummy;
          nxt_end = 1'b0;
        end
      end
      sfqc_pkg::ph_addr:
      begin
        if (dummy_r != 5'h0)
        begin
          nxt_ph = sfqc_pkg::ph_dummy;
          nxt_end = 1'b0;
        end
      end
      sfqc_pkg::ph_dummy:
      begin
      end
      default:
      begin
        nxt_ph = ph_r;
        nxt_end = (len_r <= 16'h1);
      end
    endcase
  end

  assign rise = (st_r == st_run) && !sclk_r && (div_r == HALF_END);
  assign fall_t = (st_r == st_run) && sclk_r && (div_r == HALF_END);
  assign last = (cnt_r == 6'h1);
  assign need_wr = fall_t && last && !nxt_end && (nxt_ph == sfqc_pkg::ph_wr);
  // A missing write byte holds the clock high; the flash only samples on rise.
  assign fall = fall_t && (!need_wr || wr_valid_i);
  assign wr_ready_o = need_wr;
  assign frame_end = fall && last && nxt_end;

  // ==========================================================
  // Serial clock divider
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_r <= 8'h0;
    else if (st_r != st_run || rise || fall)
      div_r <= 8'h0;
    else if (div_r != HALF_END)
      div_r <= div_r + 8'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sclk_r <= 1'b0;
    else if (rise)
      sclk_r <= 1'b1;
    else if (fall)
      sclk_r <= 1'b0;
  end

  // ==========================================================
  // Frame state machine
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= st_idle;
      ph_r <= sfqc_pkg::ph_op;
      lane_r <= sfqc_pkg::lane_1;
      addr_lane_r <= sfqc_pkg::lane_1;
      data_lane_r <= sfqc_pkg::lane_1;
      sh_r <= 32'h0;
      addr_word_r <= 32'h0;
      cnt_r <= 6'h0;
      addr_clks_r <= 6'h0;
      dummy_r <= 5'h0;
      len_r <= 16'h0;
      has_addr_r <= 1'b0;
      dir_r <= 1'b0;
      op_r <= 8'h0;
      gap_r <= 8'h0;
    end
    else
    begin
      case (st_r)
        st_idle:
        begin
          if (take && !bad)
          begin
            st_r <= st_run;
            ph_r <= sfqc_pkg::ph_op;
            op_r <= op;
            lane_r <= e_op_lane;
            sh_r <= {op, 24'h0};
            cnt_r <= sfqc_pkg::nclk(sfqc_pkg::BYTE_BITS, e_op_lane);
            has_addr_r <= e_has_addr;
            addr_word_r <= e_word;
            addr_lane_r <= e_addr_lane;
            addr_clks_r <= sfqc_pkg::nclk(e_has_mode ? sfqc_pkg::ADDR_MODE_BITS :
                                          sfqc_pkg::ADDR_BITS, e_addr_lane);
            dummy_r <= e_dummy;
            data_lane_r <= e_data_lane;
            dir_r <= cmd_i.rd_dir;
            len_r <= e_len;
          end
        end
        st_run:
        begin
          if (fall && !last)
          begin
            cnt_r <= cnt_r - 6'h1;
            case (lane_r)
              sfqc_pkg::lane_1: sh_r <= {sh_r[30:0], 1'b0};
              sfqc_pkg::lane_2: sh_r <= {sh_r[29:0], 2'h0};
              default: sh_r <= {sh_r[27:0], 4'h0};
            endcase
          end
          else if (fall)
          begin
            if (ph_r == sfqc_pkg::ph_wr || ph_r == sfqc_pkg::ph_rd)
              len_r <= len_r - 16'h1;
            if (nxt_end)
            begin
              st_r <= st_gap;
              gap_r <= 8'h0;
            end
            else
            begin
              ph_r <= nxt_ph;
              case (nxt_ph)
                sfqc_pkg::ph_addr:
                begin
                  sh_r <= addr_word_r;
                  lane_r <= addr_lane_r;
                  cnt_r <= addr_clks_r;
                end
                sfqc_pkg::ph_dummy:
                  cnt_r <= {1'b0, dummy_r};
                sfqc_pkg::ph_wr:
                begin
                  sh_r <= {wr_data_i, 24'h0};
                  lane_r <= data_lane_r;
                  cnt_r <= sfqc_pkg::nclk(sfqc_pkg::BYTE_BITS, data_lane_r);
                end
                default:
                begin
                  lane_r <= data_lane_r;
                  cnt_r <= sfqc_pkg::nclk(sfqc_pkg::BYTE_BITS, data_lane_r);
                end
              endcase
            end
          end
        end
        st_gap:
        begin
          // Select stays high a minimum time so the flash resets its decoder.
          if (gap_r == GAP_END)
            st_r <= st_idle;
          else
            gap_r <= gap_r + 8'h1;
        end
        default:
          st_r <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // Read data capture
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_r <= 8'h0;
    else if (rise && ph_r == sfqc_pkg::ph_rd)
    begin
      case (lane_r)
        sfqc_pkg::lane_1: rx_r <= {rx_r[6:0], io_s2_r[1]};
        sfqc_pkg::lane_2: rx_r <= {rx_r[5:0], io_s2_r[1:0]};
        default: rx_r <= {rx_r[3:0], io_s2_r};
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_r <= 8'h0;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= fall && last && ph_r == sfqc_pkg::ph_rd;
      if (fall && last && ph_r == sfqc_pkg::ph_rd)
        rd_data_r <= rx_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      err_r <= 1'b0;
    else
      err_r <= take && bad;
  end

  // ==========================================================
  // Shadow of device mode and latch
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      qpi_r <= 1'b0;
      wel_r <= 1'b0;
      dummy_fld_r <= sfqc_pkg::DUMMY_FLD_RST;
      wrap_fld_r <= sfqc_pkg::WRAP_FLD_RST;
    end
    else
    begin
      if (fall && need_wr && op_r == sfqc_pkg::OP_SETPARAM)
      begin
        dummy_fld_r <= wr_data_i[7:4];
        wrap_fld_r <= wr_data_i[3:0];
      end
      if (frame_end)
      begin
        case (op_r)
          sfqc_pkg::OP_WREN: wel_r <= 1'b1;
          sfqc_pkg::OP_WRDI: wel_r <= 1'b0;
          sfqc_pkg::OP_QPI_EN: qpi_r <= 1'b1;
          sfqc_pkg::OP_QPI_DIS: qpi_r <= 1'b0;
          sfqc_pkg::OP_RESET:
          begin
            qpi_r <= 1'b0;
            wel_r <= 1'b0;
          end
          sfqc_pkg::OP_PP, sfqc_pkg::OP_QPP, sfqc_pkg::OP_SE, sfqc_pkg::OP_BE32,
          sfqc_pkg::OP_BE64, sfqc_pkg::OP_CE, sfqc_pkg::OP_CE2, sfqc_pkg::OP_WRSR,
          sfqc_pkg::OP_SECPRG, sfqc_pkg::OP_SECERS:
            wel_r <= 1'b0;
          default:
            wel_r <= wel_r;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin drive
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      io_o_r <= 4'hc;
      io_oe_r <= sfqc_pkg::OE_IDLE;
    end
    else if (st_r != st_run)
    begin
      io_o_r <= {sfqc_pkg::IO_HI, 2'h0};
      io_oe_r <= sfqc_pkg::OE_IDLE;
    end
    else
    begin
      case (lane_r)
        sfqc_pkg::lane_1:
        begin
          io_o_r <= {sfqc_pkg::IO_HI, 1'b0, sh_r[31]};
          io_oe_r <= sfqc_pkg::OE_SINGLE;
        end
        sfqc_pkg::lane_2:
        begin
          io_o_r <= {sfqc_pkg::IO_HI, sh_r[31:30]};
          io_oe_r <= (ph_r == sfqc_pkg::ph_rd || ph_r == sfqc_pkg::ph_dummy) ?
                     sfqc_pkg::OE_IDLE : sfqc_pkg::OE_ALL;
        end
        default:
        begin
          io_o_r <= sh_r[31:28];
          io_oe_r <= (ph_r == sfqc_pkg::ph_rd || ph_r == sfqc_pkg::ph_dummy) ?
                     sfqc_pkg::OE_NONE : sfqc_pkg::OE_ALL;
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence

  sequence s_take_ok;
    s_take ##0 !bad;
  endsequence

  property p_wel_guard;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take ##0 (is_wr && !wel_r) |=> cmd_err_o && !busy_o;
  endproperty
  a_wel_guard: assert property (p_wel_guard) else $error("write taken without latch");

  property p_page_len;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take ##0 (is_prog && cmd_i.data_len > sfqc_pkg::PAGE_BYTES) |=> cmd_err_o;
  endproperty
  a_page_len: assert property (p_page_len) else $error("oversize program taken");

  property p_word_align;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take ##0 (op == sfqc_pkg::OP_WQIO && cmd_i.addr[0]) |=> cmd_err_o;
  endproperty
  a_word_align: assert property (p_word_align) else $error("odd word read taken");

  property p_octal_align;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take ##0 (op == sfqc_pkg::OP_OQIO && cmd_i.addr[3:0] != 4'h0) |=> cmd_err_o;
  endproperty
  a_octal_align: assert property (p_octal_align) else $error("unaligned octal read");

  property p_qpi_op;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take_ok ##0 qpi_r |=> cnt_r == 6'h2 ##1 flash_cs_b_o == 1'b0;
  endproperty
  a_qpi_op: assert property (p_qpi_op) else $error("opcode not two nibbles");

  property p_qio_dummy;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_take_ok ##0 (!qpi_r && op == sfqc_pkg::OP_QIO) |=> dummy_r == 5'h4;
  endproperty
  a_qio_dummy: assert property (p_qio_dummy) else $error("quad read dummy wrong");

  property p_wren_set;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    frame_end && op_r == sfqc_pkg::OP_WREN |=> wel_r ##1 flash_cs_b_o;
  endproperty
  a_wren_set: assert property (p_wren_set) else $error("latch not set");

  property p_wrdi_clr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    frame_end && op_r == sfqc_pkg::OP_WRDI |=> !wel_r;
  endproperty
  a_wrdi_clr: assert property (p_wrdi_clr) else $error("latch not cleared");

  property p_wren_lone;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == st_run && op_r == sfqc_pkg::OP_WREN |-> ph_r == sfqc_pkg::ph_op;
  endproperty
  a_wren_lone: assert property (p_wren_lone) else $error("write enable not lone");

  property p_idle_clk;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(flash_cs_b_o) |-> !flash_sclk_o [*2];
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock while deselected");
endmodule : sfqc_host

/* File: testbench/sfqc_flash_model.sv */
`timescale 1ns/10ps
// ====================================
// Single-lane flash device model
module sfqc_flash_model #(
  parameter logic [7:0] DEV_ID = 8'h3c
) (
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  output logic so_o,
  output logic [7:0] op_o,
  output logic wel_o
);
  logic [6:0] cnt_r = 7'h00;
  logic [7:0] sh_r = 8'h00;
  initial so_o = 1'b0;
  initial op_o = 8'h00;
  initial wel_o = 1'b0;
  always @(posedge sclk_i or posedge cs_b_i)
  begin
    if (cs_b_i)
      cnt_r <= 7'h00;
    else
    begin
      cnt_r <= cnt_r + 7'h01;
      sh_r <= {sh_r[6:0], si_i};
      if (cnt_r == 7'h07)
        op_o <= {sh_r[6:0], si_i};
    end
  end
  always @(posedge cs_b_i)
  begin
    if (cnt_r == 7'h08 && op_o == 8'h06)
      wel_o <= 1'b1;
    if (cnt_r == 7'h08 && op_o == 8'h04)
      wel_o <= 1'b0;
  end
  // A released line shows the inverse of its last level, never a held value.
  always @(negedge sclk_i or posedge cs_b_i)
  begin
    if (!cs_b_i && op_o == 8'hab && cnt_r >= 7'h20)
      so_o <= DEV_ID[~cnt_r[2:0]];
    else
      so_o <= ~so_o;
  end
endmodule : sfqc_flash_model

/* File: testbench/sfqc_host_bench.sv */
`timescale 1ns/10ps
module sfqc_host_bench;
  // The identifier value is arbitrary.
  localparam logic [7:0] DEV_ID = 8'h3c;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cv = 1'b0;
  logic wv = 1'b1;
  sfqc_pkg::sfqc_cmd_t cmd = '0;
  logic rdy, err, rdv, write_enable_latch, sclk, csb, m_so, m_wel, got_err;
  logic [7:0] rdd, m_op;
  logic bsy, fwm, wrr;
  logic md = 1'b0;
  logic [3:0] dfl, wfl;
  logic [7:0] nib = 8'h00;
  sfqc_pkg::sfqc_lane_t ln = sfqc_pkg::lane_1;
  int n_sclk = 0;
  int rises = 0;
  int nw = 0;
  logic [3:0] io_i, io_o, io_oe;
  logic [7:0] q[$];
  logic [7:0] b_op[4] = '{8'h02, 8'h48, 8'he7, 8'he3};
  logic [23:0] b_a[4] = '{24'h000100, 24'h004000, 24'h000001, 24'h000008};
  logic [15:0] b_n[4] = '{16'h0101, 16'h0001, 16'h0002, 16'h0002};
  int n_errors = 0;
  int n_checks = 0;
  assign io_i = (io_oe & io_o) | (~io_oe & {2'b11, m_so, 1'b1});
  initial forever #5 core_clk_i = ~core_clk_i;
  // Counts link clocks and keeps the last two nibbles that the host drives while selected.
  always @(posedge sclk)
  begin
    n_sclk++;
    if (!csb)
      nib <= {nib[3:0], io_o};
  end
  sfqc_host #(.HALF_CYC(4), .GAP_CYC(1)) dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .cmd_valid_i(cv), .cmd_ready_o(rdy), .cmd_i(cmd), .cmd_err_o(err), .wr_data_i(8'h5a),
    .wr_valid_i(wv), .wr_ready_o(wrr), .rd_data_o(rdd), .rd_valid_o(rdv), .busy_o(bsy),
    .four_wire_command_mode_o(fwm), .write_enable_latch_o(write_enable_latch), .dummy_count_field_o(dfl),
    .wrap_length_field_o(wfl), .flash_sclk_o(sclk), .flash_cs_b_o(csb), .io_i(io_i),
    .io_o(io_o), .io_oe_o(io_oe));
  sfqc_flash_model #(.DEV_ID(DEV_ID)) fm (.sclk_i(sclk), .cs_b_i(csb), .si_i(io_i[0]),
    .so_o(m_so), .op_o(m_op), .wel_o(m_wel));
  // ====================================
  // Tasks
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic ha,
    input logic [15:0] n, input logic rd);
    int k;
    got_err = 1'b0;
    q.delete();
    rises = n_sclk;
    nw = 0;
    @(posedge core_clk_i);
    cmd <= '{op, a, 8'h00, ha, md, ln, ln, 5'h00, rd, n};
    cv <= 1'b1;
    #1;
    while (rdy !== 1'b1)
    begin
      @(posedge core_clk_i);
      #1;
    end
    @(posedge core_clk_i);
    cv <= 1'b0;
    for (k = 0; k < 3000; k++)
    begin
      #1;
      got_err |= (err === 1'b1);
      if (rdv === 1'b1)
        q.push_back(rdd);
      if (wrr === 1'b1)
        nw++;
      if (k > 1 && rdy === 1'b1)
        break;
      @(posedge core_clk_i);
    end
    // A frame that never ends is a mismatch, not a silent pass.
    if (k == 3000)
      n_errors++;
    rises = n_sclk - rises;
  endtask : run
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // ====================================
  // Tests
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    chk("latch", 8'h00, {7'h00, write_enable_latch});
    chk("busy", 8'h00, {7'h00, bsy});
    chk("dummy field", {4'h0, sfqc_pkg::DUMMY_FLD_RST}, {4'h0, dfl});
    chk("wrap field", {4'h0, sfqc_pkg::WRAP_FLD_RST}, {4'h0, wfl});
    rst_b_i <= 1'b1;
    run(8'h06, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("latch", 8'h01, {7'h00, write_enable_latch});
    chk("dev latch", 8'h01, {7'h00, m_wel});
    chk("opcode", 8'h06, m_op);
    run(8'h04, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("latch", 8'h00, {7'h00, write_enable_latch});
    chk("dev latch", 8'h00, {7'h00, m_wel});
    run(8'h02, 24'h000100, 1'b1, 16'h1, 1'b0);
    chk("refuse", 8'h01, {7'h00, got_err});
    run(8'h06, 24'h0, 1'b0, 16'h0, 1'b0);
    foreach (b_op[i])
    begin
      run(b_op[i], b_a[i], 1'b1, b_n[i], i != 0);
      chk("refuse", 8'h01, {7'h00, got_err});
      chk("clocks", 8'h00, 8'(rises));
    end
    run(8'h75, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("refuse", 8'h00, {7'h00, got_err});
    chk("opcode", 8'h75, m_op);
    run(8'hab, 24'h0, 1'b0, 16'h2, 1'b1);
    chk("bytes", 8'h02, 8'(q.size()));
    foreach (q[i])
      chk("ident", DEV_ID, q[i]);
    run(8'h02, 24'h000100, 1'b1, 16'h1, 1'b0);
    chk("refuse", 8'h00, {7'h00, got_err});
    chk("latch", 8'h00, {7'h00, write_enable_latch});
    chk("writes", 8'h01, 8'(nw));
    run(8'h0c, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("refuse", 8'h01, {7'h00, got_err});
    run(8'hc0, 24'h0, 1'b0, 16'h1, 1'b0);
    chk("dummy field", 8'h05, {4'h0, dfl});
    chk("wrap field", 8'h0a, {4'h0, wfl});
    md = 1'b1;
    ln = sfqc_pkg::lane_2;
    run(8'hbb, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("clocks", 8'h1c, 8'(rises));
    chk("bytes", 8'h01, 8'(q.size()));
    ln = sfqc_pkg::lane_4;
    run(8'heb, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("clocks", 8'h16, 8'(rises));
    run(8'he7, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("clocks", 8'h14, 8'(rises));
    chk("bytes", 8'h01, 8'(q.size()));
    md = 1'b0;
    ln = sfqc_pkg::lane_1;
    run(8'h38, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("quad mode", 8'h01, {7'h00, fwm});
    run(8'h06, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("nibbles", 8'h06, nib);
    chk("clocks", 8'h02, 8'(rises));
    chk("latch", 8'h01, {7'h00, write_enable_latch});
    run(8'h0b, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("clocks", 8'h0f, 8'(rises));
    run(8'h0c, 24'h000100, 1'b1, 16'h1, 1'b1);
    chk("refuse", 8'h00, {7'h00, got_err});
    chk("clocks", 8'h0f, 8'(rises));
    run(8'hff, 24'h0, 1'b0, 16'h0, 1'b0);
    chk("nibbles", 8'hff, nib);
    chk("quad mode", 8'h00, {7'h00, fwm});
    end_sim();
  end
  initial
  begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule : sfqc_host_bench
